// >>> tb.sv
// self-checking testbench for the serial error-flag and tx-end block
`timescale 1ns/1ps
module tb;
	localparam logic [31:0] CT = uretc_pkg::CTRL_IDX;
	localparam logic [31:0] ST = uretc_pkg::STAT_IDX;
	localparam logic [31:0] BD = uretc_pkg::BAUD_IDX;
	localparam logic [31:0] TD = uretc_pkg::TDATA_IDX;
	localparam logic [31:0] RX = uretc_pkg::RDATA_IDX;
	localparam logic [31:0] IS = uretc_pkg::IST_IDX;
	localparam logic [31:0] IM = uretc_pkg::IMASK_IDX;
	logic sys_clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel_i = 1'b0;
	logic penable_i = 1'b0;
	logic pwrite_i = 1'b0;
	logic [31:0] paddr_i = 32'h0;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic pready_o, pslverr_o, rxd, txd_o, irq_o;
	int mismatches = 0;
	int comparisons = 0;

	always #50 sys_clk_i = ~sys_clk_i;

	uretc_top DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
		.pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd),
		.txd_o(txd_o), .irq_o(irq_o));
	uretc_peer peer (.sys_clk_i(sys_clk_i), .txd_i(txd_o), .rxd_o(rxd));

	task automatic final_report();
		$display("checks %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(input string n, input logic [31:0] s,
		input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic apb(input logic w, input logic [31:0] idx,
		input logic [31:0] wd, output logic [31:0] r, output logic err);
		int k;
		@(posedge sys_clk_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= idx << 2;
		pwdata_i <= wd;
		@(posedge sys_clk_i);
		penable_i <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge sys_clk_i);
			if (pready_o === 1'b1) break;
		end
		if (k == 20) begin
			mismatches++;
			final_report();
		end
		r = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask
	task automatic wr(input logic [31:0] idx, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, idx, d, r, e);
	endtask
	task automatic rd_chk(input string n, input logic [31:0] idx,
		input logic [31:0] x);
		logic [31:0] r;
		logic e;
		apb(1'b0, idx, 32'h0, r, e);
		check(n, r, x);
	endtask
	task automatic irq_chk(input logic x);
		repeat (3) @(posedge sys_clk_i);
		check("irq", irq_o, x);
	endtask
	// polls status until all bits of m are set
	task automatic wait_stat(input logic [31:0] m);
		logic [31:0] r;
		logic e;
		int k;
		for (k = 0; k < 40; k++) begin
			apb(1'b0, ST, 32'h0, r, e);
			if ((r & m) === m) break;
		end
		if (k == 40) begin
			mismatches++;
			final_report();
		end
	endtask

	task automatic t_reset();
		logic [31:0] r;
		logic e;
		rd_chk("control", CT, 32'h00);
		rd_chk("status", ST, 32'h84);
		check("irq", irq_o, 1'b0);
		apb(1'b0, 32'h0, 32'h0, r, e);
		check("unmapped err", e, 1'b1);
		check("unmapped data", r, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_framing();
		wr(BD, 32'h0);
		wr(CT, 32'h50);
		wr(IM, 32'h2);
		peer.send(8'ha5, 1'b0, 1'b0, 1'b1);
		wait_stat(32'h10);
		rd_chk("framing set", ST, 32'h94);
		irq_chk(1'b1);
		wr(IM, 32'h0);
		irq_chk(1'b0);
		wr(IM, 32'h2);
		wr(ST, 32'hff);
		wr(ST, 32'h00);
		rd_chk("framing kept", ST, 32'h94);
		wr(ST, 32'h00);
		rd_chk("framing clear", ST, 32'h84);
		wr(IS, 32'h2);
		rd_chk("int status", IS, 32'h0);
		irq_chk(1'b0);
		$display("framing test done");
	endtask
	task automatic t_parity();
		wr(CT, 32'h12);
		peer.send(8'h33, 1'b1, 1'b1, 1'b0);
		wait_stat(32'h08);
		rd_chk("parity set", ST, 32'h8c);
		rd_chk("err req gated", IS, 32'h0);
		wr(ST, 32'hff);
		wr(ST, 32'h00);
		rd_chk("parity kept", ST, 32'h8c);
		wr(ST, 32'h00);
		rd_chk("parity clear", ST, 32'h84);
		$display("parity test done");
	endtask
	task automatic t_overrun();
		// odd parity: the peer's flipped parity bit is now the right one
		wr(CT, 32'h13);
		peer.send(8'h33, 1'b1, 1'b1, 1'b0);
		wait_stat(32'h40);
		rd_chk("rx full", ST, 32'hc4);
		peer.send(8'h5a, 1'b1, 1'b1, 1'b0);
		wait_stat(32'h20);
		rd_chk("overrun set", ST, 32'he4);
		rd_chk("rx data kept", RX, 32'h33);
		wr(ST, 32'h00);
		rd_chk("overrun clear", ST, 32'h84);
		$display("overrun test done");
	endtask
	task automatic t_txend();
		int n;
		wr(CT, 32'h00);
		wr(IM, 32'h4);
		irq_chk(1'b0);
		rd_chk("tx end blocked", IS, 32'h0);
		wr(CT, 32'h04);
		irq_chk(1'b1);
		wr(CT, 32'h00);
		wr(IS, 32'h4);
		irq_chk(1'b0);
		n = peer.frames;
		wr(TD, 32'hc3);
		repeat (400) @(posedge sys_clk_i);
		check("no frame", peer.frames, n);
		wr(CT, 32'h20);
		for (int k = 0; k < 400 && peer.frames == n; k++)
			@(posedge sys_clk_i);
		check("frame count", peer.frames, n + 1);
		check("frame data", peer.got, 8'hc3);
		$display("tx end test done");
	endtask

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_framing();
		t_parity();
		t_overrun();
		t_txend();
		final_report();
	end
endmodule

// >>> uretc_flag.sv
// status flag cleared by a zero write after it has been read as one
`timescale 1ns/1ps
module uretc_flag #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic set_i,
	input wire logic seen_i,
	input wire logic wr_i,
	input wire logic wbit_i,
	output logic flag_o
);
	logic armed;

	// a read that returned one arms the clear; any status write consumes it
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed <= 1'b0;
		end else if (wr_i) begin
			armed <= 1'b0;
		end else if (seen_i) begin
			armed <= 1'b1;
		end
	end

	// set wins over clear; a written one does nothing
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			flag_o <= RST_VAL;
		end else if (set_i) begin
			flag_o <= 1'b1;
		end else if (wr_i && !wbit_i && armed) begin
			flag_o <= 1'b0;
		end
	end
endmodule

// >>> uretc_peer.sv
// remote serial partner: sends frames to the block and collects its frames
`timescale 1ns/1ps
module uretc_peer #(
	parameter int BIT_CLKS = 16
) (
	input wire logic sys_clk_i,
	input wire logic txd_i,
	output logic rxd_o
);
	logic [7:0] got;
	int frames;
	initial begin
		rxd_o = 1'b1;
		got = 8'h00;
		frames = 0;
	end
	// even parity; a bad stop bit stays low just past its middle, so the
	// receiver drops the tail of it as a false start at its mid-bit check
	task automatic send(input logic [7:0] d, input logic par_en,
		input logic bad_par, input logic bad_stop);
		logic [10:0] b;
		int n;
		b = par_en ? {1'b1, ^d ^ bad_par, d, 1'b0} : {2'b11, d, 1'b0};
		n = par_en ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge sys_clk_i);
			if (i == n - 1 && bad_stop) begin
				rxd_o <= 1'b0;
				repeat (10) @(posedge sys_clk_i);
			end else begin
				rxd_o <= b[i];
				repeat (BIT_CLKS - 1) @(posedge sys_clk_i);
			end
		end
		@(posedge sys_clk_i);
		rxd_o <= 1'b1;
		repeat (BIT_CLKS) @(posedge sys_clk_i);
	endtask
	// collects each frame the block sends, sampling at the bit middle
	always begin
		@(posedge sys_clk_i);
		if (txd_i === 1'b0) begin
			repeat (BIT_CLKS / 2) @(posedge sys_clk_i);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge sys_clk_i);
				got[i] = txd_i;
			end
			repeat (BIT_CLKS) @(posedge sys_clk_i);
			frames++;
		end
	end
endmodule

// >>> uretc_pkg.sv
// constants and types shared by the serial error-flag and transmit-end block
package uretc_pkg;
	// printed offsets are register indices; byte address is four times index
	localparam logic [31:0] BAUD_IDX = 32'h00ffff80;
	localparam logic [31:0] CTRL_IDX = 32'h00ffff82;
	localparam logic [31:0] TDATA_IDX = 32'h00ffff83;
	localparam logic [31:0] STAT_IDX = 32'h00ffff84;
	localparam logic [31:0] RDATA_IDX = 32'h00ffff85;
	localparam logic [31:0] IST_IDX = 32'h00ffff86;
	localparam logic [31:0] IMASK_IDX = 32'h00ffff87;

	// serial_control fields
	localparam int CTL_RIE = 6;
	localparam int CTL_TE = 5;
	localparam int CTL_RE = 4;
	localparam int CTL_TX_END_IRQ_ENABLE = 2;
	localparam int CTL_PEN = 1;
	localparam int CTL_PODD = 0;

	// serial_status fields; the four flags at PARITY_ERROR_FLAG..RDRF are contiguous
	localparam int STAT_TDRE = 7;
	localparam int STAT_RDRF = 6;
	localparam int STAT_OVERRUN_ERROR_FLAG = 5;
	localparam int STAT_FER = 4;
	localparam int STAT_PER = 3;
	localparam int STAT_TEND = 2;
	localparam int NFLAGS = 4;

	// interrupt status and mask fields
	localparam int IRQ_RXI = 0;
	localparam int IRQ_ERI = 1;
	localparam int IRQ_TEI = 2;
	localparam int IRQ_W = 3;

	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [15:0] BAUD_RST = 16'h0003;
	localparam logic [IRQ_W-1:0] IMASK_RST = 3'h0;

	// sixteen ticks per bit, sampled at the middle
	localparam logic [3:0] OVS_LAST = 4'hf;
	localparam logic [3:0] OVS_MID = 4'h7;
	localparam logic [3:0] BITS_PAR = 4'h8;
	localparam logic [3:0] BITS_NOPAR = 4'h7;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_START = 2'b01,
		ST_DATA = 2'b11,
		ST_STOP = 2'b10
	} uretc_state_t;

	typedef struct packed {
		logic tdre;
		logic rdrf;
		logic overrun_error_flag;
		logic framing_error_flag;
		logic parity_error_flag;
		logic tend;
		logic [1:0] rsv;
	} uretc_stat_t;
endpackage

// >>> uretc_tick.sv
// oversampling tick generator, one pulse every div+1 clocks
`timescale 1ns/1ps
module uretc_tick (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] div_i,
	output logic tick_o
);
	logic [15:0] cnt;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt >= div_i) begin
			cnt <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt <= cnt + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule

// >>> uretc_top.sv
// serial channel with receive error flags and transmit-end control on APB
// Operation
// (R1) framing error during reception sets status bit 4
// (R2) framing flag clears only by zero write after reading it as one
// (R3) parity error during reception sets status bit 3
// (R4) parity flag clears only by zero write after reading it as one
// (R5) writing one to an error flag has no effect
// (R6) handler should reread a flag after writing zero to it
// (R7) control bit 2 gates the transmit-end interrupt request
// (R8) receive interrupt enable gates receive-data and receive-error requests
// (R9) overrun sets status bit 5, cleared by zero write after read
// (R10) new characters are sent only while transmit enable is one
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module uretc_top (
	input wire logic sys_clk_i,
	input wire logic rst_n_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic rxd_i,
	output logic txd_o,
	output logic irq_o
);
	logic setup;
	logic xfer;
	logic wr_en;
	logic rd_en;
	logic map_ok;
	logic [31:0] next_rdata;
	logic wr_ctrl;
	logic wr_baud;
	logic wr_tdata;
	logic wr_stat;
	logic rd_stat;
	logic wr_ist;
	logic wr_imask;

	localparam int IRQ_W_L = uretc_pkg::IRQ_W;
	localparam int NF = uretc_pkg::NFLAGS;

	logic [7:0] ctrl;
	logic [15:0] baud;
	logic [7:0] tdata;
	logic [7:0] rdata;
	logic tdre;
	logic tend;
	logic [IRQ_W_L-1:0] ist;
	logic [IRQ_W_L-1:0] imask;
	logic [IRQ_W_L-1:0] req;
	uretc_pkg::uretc_stat_t stat;

	logic [NF-1:0] flg;
	logic [NF-1:0] flg_set;
	logic tick;

	uretc_pkg::uretc_state_t tx_st;
	logic [3:0] tx_ov;
	logic [3:0] tx_cnt;
	logic [8:0] tx_sh;
	logic tx_take;
	logic tx_done;

	uretc_pkg::uretc_state_t rx_st;
	logic [3:0] rx_ov;
	logic [3:0] rx_cnt;
	logic [8:0] rx_sh;
	logic rx_done;
	logic rx_stop_bad;
	logic [7:0] rx_byte;
	logic rx_par_bad;

	logic [3:0] nbits_last;
	logic pen;

	function automatic logic [31:0] adr(input logic [31:0] idx);
		adr = {idx[29:0], 2'b00};
	endfunction

	assign setup = psel_i & ~penable_i;
	assign xfer = psel_i & penable_i & pready_o;
	assign wr_en = xfer & pwrite_i;
	assign rd_en = xfer & ~pwrite_i;
	assign pen = ctrl[uretc_pkg::CTL_PEN];
	assign nbits_last = pen ? uretc_pkg::BITS_PAR : uretc_pkg::BITS_NOPAR;

	assign stat = {tdre, flg[3], flg[2], flg[1], flg[0], tend, 2'b00};

	// read mux and address decode
	always_comb begin
		next_rdata = 32'h00000000;
		map_ok = 1'b1;
		if (paddr_i == adr(uretc_pkg::CTRL_IDX)) begin
			next_rdata = {24'h000000, ctrl};
		end else if (paddr_i == adr(uretc_pkg::STAT_IDX)) begin
			next_rdata = {24'h000000, stat};
		end else if (paddr_i == adr(uretc_pkg::BAUD_IDX)) begin
			next_rdata = {16'h0000, baud};
		end else if (paddr_i == adr(uretc_pkg::TDATA_IDX)) begin
			next_rdata = {24'h000000, tdata};
		end else if (paddr_i == adr(uretc_pkg::RDATA_IDX)) begin
			next_rdata = {24'h000000, rdata};
		end else if (paddr_i == adr(uretc_pkg::IST_IDX)) begin
			next_rdata = {29'h0, ist};
		end else if (paddr_i == adr(uretc_pkg::IMASK_IDX)) begin
			next_rdata = {29'h0, imask};
		end else begin
			map_ok = 1'b0;
		end
	end

	assign wr_ctrl = wr_en && paddr_i == adr(uretc_pkg::CTRL_IDX);
	assign wr_baud = wr_en && paddr_i == adr(uretc_pkg::BAUD_IDX);
	assign wr_tdata = wr_en && paddr_i == adr(uretc_pkg::TDATA_IDX);
	assign wr_stat = wr_en && paddr_i == adr(uretc_pkg::STAT_IDX);
	assign rd_stat = rd_en && paddr_i == adr(uretc_pkg::STAT_IDX);
	assign wr_ist = wr_en && paddr_i == adr(uretc_pkg::IST_IDX);
	assign wr_imask = wr_en && paddr_i == adr(uretc_pkg::IMASK_IDX);

	// no wait state: data is captured in setup and returned in the first access cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end else if (setup) begin
			prdata_o <= pwrite_i ? 32'h00000000 : next_rdata;
			pready_o <= 1'b1;
			pslverr_o <= ~map_ok;
		end else begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl <= uretc_pkg::CTRL_RST;
		end else if (wr_ctrl) begin
			ctrl <= pwdata_i[7:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			baud <= uretc_pkg::BAUD_RST;
		end else if (wr_baud) begin
			baud <= pwdata_i[15:0];
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			imask <= uretc_pkg::IMASK_RST;
		end else if (wr_imask) begin
			imask <= pwdata_i[IRQ_W_L-1:0];
		end
	end

	uretc_tick u_tick (
		.sys_clk_i(sys_clk_i),
		.rst_n_i(rst_n_i),
		.div_i(baud),
		.tick_o(tick)
	);

	// error and receive-full flags, status bits PARITY_ERROR_FLAG upward
	assign flg_set[0] = rx_done & pen & rx_par_bad; // R3
	assign flg_set[1] = rx_done & rx_stop_bad; // R1
	assign flg_set[2] = rx_done & flg[3]; // R9
	assign flg_set[3] = rx_done & ~flg[3] & ~rx_stop_bad &
		~(pen & rx_par_bad);

	generate
		for (genvar i = 0; i < NF; i++) begin : g_flag
			uretc_flag u_flag (
				.sys_clk_i(sys_clk_i),
				.rst_n_i(rst_n_i),
				.set_i(flg_set[i]),
				.seen_i(rd_stat & prdata_o[uretc_pkg::STAT_PER + i]),
				.wr_i(wr_stat),
				.wbit_i(pwdata_i[uretc_pkg::STAT_PER + i]), // R2 R4 R5
				.flag_o(flg[i])
			);
		end
	endgenerate

	// transmit holding register
	assign tx_take = tx_st == uretc_pkg::ST_IDLE &&
		ctrl[uretc_pkg::CTL_TE] && !tdre && !wr_tdata; // R10

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tdata <= 8'h00;
			tdre <= 1'b1;
		end else if (wr_tdata) begin
			tdata <= pwdata_i[7:0];
			tdre <= 1'b0;
		end else if (tx_take) begin
			tdre <= 1'b1;
		end
	end

	// transmit end: last stop bit sent with nothing waiting
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tend <= 1'b1;
		end else if (tx_done && tdre) begin
			tend <= 1'b1;
		end else if (tx_take) begin
			tend <= 1'b0;
		end
	end

	assign tx_done = tick && tx_st == uretc_pkg::ST_STOP &&
		tx_ov == uretc_pkg::OVS_LAST;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_st <= uretc_pkg::ST_IDLE;
			tx_ov <= 4'h0;
			tx_cnt <= 4'h0;
			tx_sh <= 9'h1ff;
		end else begin
			case (tx_st)
			uretc_pkg::ST_IDLE: begin
				tx_ov <= 4'h0;
				tx_cnt <= 4'h0;
				if (tx_take) begin
					tx_sh <= {(^tdata) ^ ctrl[uretc_pkg::CTL_PODD], tdata};
					tx_st <= uretc_pkg::ST_START;
				end
			end
			uretc_pkg::ST_START: begin
				if (tick) begin
					tx_ov <= tx_ov + 4'h1;
					if (tx_ov == uretc_pkg::OVS_LAST) begin
						tx_st <= uretc_pkg::ST_DATA;
					end
				end
			end
			uretc_pkg::ST_DATA: begin
				if (tick) begin
					tx_ov <= tx_ov + 4'h1;
					if (tx_ov == uretc_pkg::OVS_LAST) begin
						tx_sh <= {1'b1, tx_sh[8:1]};
						tx_cnt <= tx_cnt + 4'h1;
						if (tx_cnt == nbits_last) begin
							tx_st <= uretc_pkg::ST_STOP;
						end
					end
				end
			end
			default: begin
				if (tick) begin
					tx_ov <= tx_ov + 4'h1;
					if (tx_ov == uretc_pkg::OVS_LAST) begin
						tx_st <= uretc_pkg::ST_IDLE;
					end
				end
			end
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			txd_o <= 1'b1;
		end else if (tx_st == uretc_pkg::ST_START) begin
			txd_o <= 1'b0;
		end else if (tx_st == uretc_pkg::ST_DATA) begin
			txd_o <= tx_sh[0];
		end else begin
			txd_o <= 1'b1;
		end
	end

	// receiver: start found on a tick, checked mid-bit, then every 16 ticks
	assign rx_done = tick && rx_st == uretc_pkg::ST_STOP &&
		rx_ov == uretc_pkg::OVS_LAST;
	assign rx_stop_bad = ~rxd_i;
	assign rx_byte = pen ? rx_sh[7:0] : rx_sh[8:1];
	assign rx_par_bad = (^rx_sh) != ctrl[uretc_pkg::CTL_PODD];

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_st <= uretc_pkg::ST_IDLE;
			rx_ov <= 4'h0;
			rx_cnt <= 4'h0;
			rx_sh <= 9'h000;
		end else if (tick) begin
			case (rx_st)
			uretc_pkg::ST_IDLE: begin
				rx_ov <= 4'h0;
				rx_cnt <= 4'h0;
				if (ctrl[uretc_pkg::CTL_RE] && !rxd_i) begin
					rx_st <= uretc_pkg::ST_START;
				end
			end
			uretc_pkg::ST_START: begin
				rx_ov <= rx_ov + 4'h1;
				if (rx_ov == uretc_pkg::OVS_MID) begin
					rx_ov <= 4'h0;
					rx_st <= rxd_i ? uretc_pkg::ST_IDLE : uretc_pkg::ST_DATA;
				end
			end
			uretc_pkg::ST_DATA: begin
				rx_ov <= rx_ov + 4'h1;
				if (rx_ov == uretc_pkg::OVS_LAST) begin
					rx_sh <= {rxd_i, rx_sh[8:1]};
					rx_cnt <= rx_cnt + 4'h1;
					if (rx_cnt == nbits_last) begin
						rx_st <= uretc_pkg::ST_STOP;
					end
				end
			end
			default: begin
				rx_ov <= rx_ov + 4'h1;
				if (rx_ov == uretc_pkg::OVS_LAST) begin
					rx_st <= uretc_pkg::ST_IDLE;
				end
			end
			endcase
		end
	end

	// data held while the full flag is up is kept; the new byte is lost
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata <= 8'h00;
		end else if (flg_set[3]) begin
			rdata <= rx_byte;
		end
	end

	// interrupt requests, sticky status, write one to clear, set wins
	assign req[uretc_pkg::IRQ_RXI] = flg[3] & ctrl[uretc_pkg::CTL_RIE]; // R8
	assign req[uretc_pkg::IRQ_ERI] = |flg[2:0] & ctrl[uretc_pkg::CTL_RIE]; // R8
	assign req[uretc_pkg::IRQ_TEI] = tend & ctrl[uretc_pkg::CTL_TX_END_IRQ_ENABLE]; // R7

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ist <= 3'h0;
		end else if (wr_ist) begin
			ist <= req | (ist & ~pwdata_i[IRQ_W_L-1:0]);
		end else begin
			ist <= req | ist;
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_o <= 1'b0;
		end else begin
			irq_o <= |(ist & imask);
		end
	end

	default clocking dc @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// checker copy of the read-as-one history of framing (1) and parity (0)
	logic [1:0] err_seen;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			err_seen <= 2'h0;
		end else if (wr_stat) begin
			err_seen <= 2'h0;
		end else if (rd_stat) begin
			err_seen <= err_seen |
				prdata_o[uretc_pkg::STAT_FER:uretc_pkg::STAT_PER];
		end
	end

	sequence fer_zero_write;
		wr_stat && !pwdata_i[uretc_pkg::STAT_FER];
	endsequence

	sequence per_zero_write;
		wr_stat && !pwdata_i[uretc_pkg::STAT_PER];
	endsequence

	framing_set_a: assert property (flg_set[1] |=> stat.framing_error_flag) // R1
		else $error("framing flag not set");
	framing_clear_a: assert property ($fell(stat.framing_error_flag) |-> // R2
		$past(wr_stat && !pwdata_i[uretc_pkg::STAT_FER]))
		else $error("framing flag cleared without zero write");
	parity_set_a: assert property (flg_set[0] |=> stat.parity_error_flag) // R3
		else $error("parity flag not set");
	parity_clear_a: assert property (per_zero_write ##0 stat.parity_error_flag // R4
		##0 !flg_set[0] ##0 err_seen[0] |=> !stat.parity_error_flag)
		else $error("parity flag kept after read and zero write");
	write_one_a: assert property (wr_stat && stat.framing_error_flag && // R5
		pwdata_i[uretc_pkg::STAT_FER] |=> stat.framing_error_flag)
		else $error("writing one cleared framing flag");
	fer_zero_held_a: assert property (fer_zero_write ##0 stat.framing_error_flag // R2
		##0 !err_seen[1] |=> stat.framing_error_flag)
		else $error("framing flag cleared without prior read");
	tx_end_gate_a: assert property ($rose(ist[uretc_pkg::IRQ_TEI]) // R7
		|-> $past(ctrl[uretc_pkg::CTL_TX_END_IRQ_ENABLE] && tend))
		else $error("transmit-end request raised while blocked");
	rx_gate_a: assert property ($rose(ist[uretc_pkg::IRQ_ERI]) || // R8
		$rose(ist[uretc_pkg::IRQ_RXI]) |-> $past(ctrl[uretc_pkg::CTL_RIE]))
		else $error("receive request raised while disabled");
	overrun_set_a: assert property (rx_done && stat.rdrf // R9
		|=> stat.overrun_error_flag && $stable(rdata))
		else $error("overrun not flagged or data overwritten");
	tx_enable_a: assert property (tx_st == uretc_pkg::ST_IDLE ##1 // R10
		tx_st == uretc_pkg::ST_START |-> $past(ctrl[uretc_pkg::CTL_TE]))
		else $error("character started with transmit disabled");
endmodule
